// ### rtl/pixel_shift_map.vh
// Purpose: Register offsets, fields, reset values and sizes for the pixel shift formatter
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef PIXEL_SHIFT_MAP_VH
`define PIXEL_SHIFT_MAP_VH

// ****************************************
// Register byte addresses
// ****************************************
`define CTRL_ADDR        12'h000
`define STATUS_ADDR      12'h004
`define TBL_ADDR_ADDR    12'h008
`define TBL_DATA_ADDR    12'h00c

// ****************************************
// Control fields
// ****************************************
`define CTRL_SHIFT_LSB   0
`define CTRL_SHIFT_MSB   1
`define CTRL_WIDTH8_BIT  2
`define CTRL_TEST_BIT    3
`define CTRL_RESET       4'h0

// ****************************************
// Shift codes and sizes
// ****************************************
`define SHIFT_NONE       2'h0
`define SHIFT_ONCE       2'h1
`define SHIFT_TWICE      2'h2
`define SHIFT_THREE      2'h3
`define LINE_PIXELS      2048
`define PIX_IDX_W        11
`define LAST_PIX         11'h7ff

`endif

// ### rtl/pixel_digital_shift_formatter.v
// Purpose: Digital shift and width formatting of converter samples, with a shading table test line
// Assumes: Converter samples arrive with line and data valid, synchronous to pclk
// Notes:   One cycle from input to output; table written and read over APB
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pixel_shift_map.vh"

// Function
// - Test mode sends stored shading entries in pixel order as one image line
// - Nonzero shift multiplies output by two, four or eight via left shift
// - Ten-bit, no shift: all ten converter bits pass unchanged
// - Ten-bit, shift once: bits eight..zero then one zero
// - Ten-bit, shift twice: bits seven..zero then two zeros
// - Ten-bit, shift three: bits six..zero then three zeros
// - Shift once: bit nine set forces output all ones
// - Shift twice: bit nine or eight set forces all ones
// - Shift three: bit nine, eight or seven set forces all ones
// - Eight-bit, no shift: output converter bits nine..two
// - Eight-bit, shift once: output bits eight..one
// - Eight-bit, shift twice: output bits seven..zero
// - Eight-bit, shift three: bits six..zero then one zero
// - Table entries are eight-bit unsigned values, one per pixel, output directly
module pixel_digital_shift_formatter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [9:0]  adc_data,
  input  wire        adc_dval,
  input  wire        adc_lval,
  output reg  [9:0]  pix_data,
  output reg         pix_dval,
  output reg         pix_lval
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [3:0]            ctrl_q;
  reg  [3:0]            ctrl_d;
  reg  [`PIX_IDX_W-1:0] tbl_addr_q;
  reg  [`PIX_IDX_W-1:0] tbl_addr_d;
  reg                   pready_d;
  reg                   pslverr_d;
  reg  [31:0]           prdata_d;
  reg                   lval_d1_q;
  reg  [1:0]            line_shift_q;
  reg                   line_width8_q;
  reg                   line_test_q;
  reg  [`PIX_IDX_W-1:0] pix_idx_q;
  reg  [`PIX_IDX_W-1:0] pix_idx_d;
  reg  [7:0]            shade_mem [0:`LINE_PIXELS-1];
  reg  [31:0]           rdata_d;
  reg                   addr_ok;
  reg                   sat_hit;
  reg  [9:0]            fmt10_d;
  reg  [7:0]            fmt8_d;
  reg  [9:0]            fmt_d;
  reg  [9:0]            pix_data_d;
  reg                   pix_dval_d;

  // ****************************************
  // Nets
  // ****************************************
  wire                  access;
  wire                  take;
  wire                  wr_en;
  wire                  rd_en;
  wire                  sel_ctrl;
  wire                  sel_status;
  wire                  sel_tbl_addr;
  wire                  sel_tbl_data;
  wire [`PIX_IDX_W-1:0] tbl_step;
  wire                  pix_take;
  wire                  line_new;
  wire [1:0]            cur_shift;
  wire                  cur_width8;
  wire                  cur_test;
  wire [`PIX_IDX_W-1:0] cur_idx;
  wire                  idx_at_end;
  wire [`PIX_IDX_W-1:0] idx_step;
  wire [7:0]            shade_val;
  wire [2:0]            top_bits;
  wire                  sat_once;
  wire                  sat_twice;
  wire                  sat_three;

  // ****************************************
  // APB decode, one wait state
  // ****************************************
  assign access       = psel & penable;
  // Only the first access cycle is taken; pready answers in the next one
  assign take         = access & ~pready;
  assign wr_en        = take & pwrite;
  assign rd_en        = take & ~pwrite;
  assign sel_ctrl     = (paddr == `CTRL_ADDR);
  assign sel_status   = (paddr == `STATUS_ADDR);
  assign sel_tbl_addr = (paddr == `TBL_ADDR_ADDR);
  assign sel_tbl_data = (paddr == `TBL_DATA_ADDR);

  // ****************************************
  // Read data and response
  // ****************************************
  always @* begin
    addr_ok = 1'b1;
    rdata_d = 32'h0000_0000;
    if (sel_ctrl) begin
      rdata_d = {28'h0000000, ctrl_q};
    end else if (sel_status) begin
      rdata_d = {16'h0000, line_test_q, line_width8_q, line_shift_q, lval_d1_q, pix_idx_q};
    end else if (sel_tbl_addr) begin
      rdata_d = {21'h000000, tbl_addr_q};
    end else if (sel_tbl_data) begin
      rdata_d = {24'h000000, shade_mem[tbl_addr_q]};
    end else begin
      // Unmapped reads return zero and flag an error
      addr_ok = 1'b0;
    end
  end

  always @* begin
    pready_d  = take;
    pslverr_d = take & ~addr_ok;
    prdata_d  = prdata;
    if (rd_en) begin
      prdata_d = rdata_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_d;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_en && sel_ctrl) begin
      ctrl_d = pwdata[3:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************
  // Shading table
  // ****************************************
  assign tbl_step = tbl_addr_q + {{(`PIX_IDX_W-1){1'b0}}, 1'b1};

  always @* begin
    tbl_addr_d = tbl_addr_q;
    if (wr_en && sel_tbl_addr) begin
      tbl_addr_d = pwdata[`PIX_IDX_W-1:0];
    end else if ((wr_en || rd_en) && sel_tbl_data) begin
      // Port auto-increments so an upload is a plain burst of writes
      tbl_addr_d = tbl_step;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_addr_q <= {`PIX_IDX_W{1'b0}};
    end else begin
      tbl_addr_q <= tbl_addr_d;
    end
  end

  // Table memory has no reset; contents are software's to load
  always @(posedge pclk) begin
    if (wr_en && sel_tbl_data) begin
      shade_mem[tbl_addr_q] <= pwdata[7:0];
    end
  end

  // ****************************************
  // Line tracking
  // ****************************************
  assign pix_take   = adc_dval & adc_lval;
  assign line_new   = adc_lval & ~lval_d1_q;
  // Settings latch at line start so a mid-line write cannot tear a line
  assign cur_shift  = line_new ? ctrl_q[`CTRL_SHIFT_MSB:`CTRL_SHIFT_LSB] : line_shift_q;
  assign cur_width8 = line_new ? ctrl_q[`CTRL_WIDTH8_BIT] : line_width8_q;
  assign cur_test   = line_new ? ctrl_q[`CTRL_TEST_BIT] : line_test_q;
  assign cur_idx    = line_new ? {`PIX_IDX_W{1'b0}} : pix_idx_q;
  assign idx_at_end = (cur_idx == `LAST_PIX);
  assign idx_step   = cur_idx + {{(`PIX_IDX_W-1){1'b0}}, 1'b1};
  assign shade_val  = shade_mem[cur_idx];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lval_d1_q <= 1'b0;
    end else begin
      lval_d1_q <= adc_lval;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_shift_q  <= `SHIFT_NONE;
      line_width8_q <= 1'b0;
      line_test_q   <= 1'b0;
    end else begin
      line_shift_q  <= cur_shift;
      line_width8_q <= cur_width8;
      line_test_q   <= cur_test;
    end
  end

  always @* begin
    pix_idx_d = cur_idx;
    // Index stops at the table end; longer lines repeat the last entry
    if (pix_take && !idx_at_end) begin
      pix_idx_d = idx_step;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_idx_q <= {`PIX_IDX_W{1'b0}};
    end else begin
      pix_idx_q <= pix_idx_d;
    end
  end

  // ****************************************
  // Saturation
  // ****************************************
  assign top_bits  = adc_data[9:7];
  assign sat_once  = top_bits[2];
  assign sat_twice = |top_bits[2:1];
  assign sat_three = |top_bits;

  always @* begin
    sat_hit = 1'b0;
    case (cur_shift)
      `SHIFT_NONE:  sat_hit = 1'b0;
      `SHIFT_ONCE:  sat_hit = sat_once;
      `SHIFT_TWICE: sat_hit = sat_twice;
      `SHIFT_THREE: sat_hit = sat_three;
      default:      sat_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Bit group selection
  // ****************************************
  always @* begin
    fmt10_d = adc_data;
    case (cur_shift)
      `SHIFT_NONE:  fmt10_d = adc_data;
      `SHIFT_ONCE:  fmt10_d = {adc_data[8:0], 1'b0};
      `SHIFT_TWICE: fmt10_d = {adc_data[7:0], 2'h0};
      `SHIFT_THREE: fmt10_d = {adc_data[6:0], 3'h0};
      default:      fmt10_d = adc_data;
    endcase
  end

  always @* begin
    fmt8_d = adc_data[9:2];
    case (cur_shift)
      `SHIFT_NONE:  fmt8_d = adc_data[9:2];
      `SHIFT_ONCE:  fmt8_d = adc_data[8:1];
      `SHIFT_TWICE: fmt8_d = adc_data[7:0];
      `SHIFT_THREE: fmt8_d = {adc_data[6:0], 1'b0};
      default:      fmt8_d = adc_data[9:2];
    endcase
  end

  // ****************************************
  // Output word
  // ****************************************
  always @* begin
    fmt_d = 10'h000;
    if (cur_test) begin
      // Table value goes out unshifted, in the low byte of the word
      fmt_d = {2'h0, shade_val};
    end else if (cur_width8) begin
      fmt_d = sat_hit ? 10'h0ff : {2'h0, fmt8_d};
    end else begin
      fmt_d = sat_hit ? 10'h3ff : fmt10_d;
    end
  end

  always @* begin
    pix_dval_d = pix_take;
    pix_data_d = 10'h000;
    if (pix_take) begin
      pix_data_d = fmt_d;
    end
  end

  // Timing and valids follow the sensor stream in every mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_lval <= 1'b0;
    end else begin
      pix_lval <= adc_lval;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_dval <= 1'b0;
    end else begin
      pix_dval <= pix_dval_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_data <= 10'h000;
    end else begin
      pix_data <= pix_data_d;
    end
  end

endmodule // pixel_digital_shift_formatter

// ### testbench/pds_grabber.sv
// Purpose: Frame grabber end of the pixel video link
// Assumes: No back-pressure exists on this link
// Notes:   Only framed pixels are handed on
`timescale 1ns/1ps
module pds_grabber (
  input  wire logic       pix_dval,
  input  wire logic       pix_lval,
  input  wire logic [9:0] pix_data,
  output logic            got,
  output logic [9:0]      gd
);
  // Data outside a line is junk to a grabber
  assign got = pix_lval && pix_dval;
  assign gd  = pix_data;
endmodule // pds_grabber

// ### testbench/pds_chk.sv
// Purpose: Port checker of the pixel formatter
// Assumes: Aligned APB addresses
// Notes:   Snoops control writes to know the line setting
`timescale 1ns/1ps
module pds_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [9:0]  adc_data,
  input wire logic [9:0]  pix_data,
  input wire logic        adc_dval,
  input wire logic        adc_lval,
  input wire logic        pix_dval,
  input wire logic        pix_lval
);
  logic [3:0]  cq, lq;
  logic        lv;
  wire  [3:0]  ef = (adc_lval && !lv) ? cq : lq;
  wire  [12:0] u  = {3'h0, adc_data} << ef[1:0];
  wire         pv = adc_dval && adc_lval;
  // Setting taken at line start only, so a write mid-line cannot split a line
  always @(posedge pclk or negedge presetn)
    if (!presetn) {cq, lq, lv} <= 9'h0;
    else begin
      if (psel && penable && pwrite && !pready && paddr == 12'h000) cq <= pwdata[3:0];
      lq <= ef;
      lv <= adc_lval;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_map_a: assert property (pready |-> pslverr ==
    !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00c)) else $error("bad pslverr");
  lval_dly_a: assert property (adc_lval |=> pix_lval) else $error("lval lost");
  idle_out_a: assert property (!pv |=> !pix_dval && pix_data == 10'h000) else $error("idle out");
  sat_ones_a: assert property (pv && !ef[3] && |u[12:10] |=>
    pix_data == ($past(ef[2]) ? 10'h0ff : 10'h3ff)) else $error("no saturation");
  shift_ten_a: assert property (pv && ef[3:2] == 2'h0 && !(|u[12:10]) |=>
    pix_data == $past(u[9:0])) else $error("bad 10-bit");
  shift_eight_a: assert property (pv && ef[3:2] == 2'h1 && !(|u[12:10]) |=>
    pix_data == {2'h0, $past(u[9:2])}) else $error("bad 8-bit");
  table_byte_a: assert property (pv && ef[3] |=> pix_dval && pix_data[9:8] == 2'h0) else $error("bad test");
  cover property (pv && ef[3]);
  cover property (pv && !ef[3] && |u[12:10]);
  cover property (pready && pslverr);
endmodule // pds_chk
bind pixel_digital_shift_formatter pds_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .adc_data(adc_data),
  .pix_data(pix_data), .adc_dval(adc_dval), .adc_lval(adc_lval), .pix_dval(pix_dval), .pix_lval(pix_lval));

// ### testbench/tb_pixel_digital_shift_formatter.sv
// Purpose: Self-checking bench of the pixel formatter
// Assumes: One wait state on APB, one cycle stream latency
// Notes:   Sixteen-pixel lines keep the run short
`timescale 1ns/1ps
module tb_pixel_digital_shift_formatter;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        adc_dval, adc_lval, pix_dval, pix_lval, got;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [9:0]  adc_data, pix_data, gd;
  logic [7:0]  tbl [16];
  logic [9:0]  q [$];
  int          bad_count, n_tests;
  pixel_digital_shift_formatter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_data(adc_data), .adc_dval(adc_dval), .adc_lval(adc_lval), .pix_data(pix_data), .pix_dval(pix_dval),
    .pix_lval(pix_lval));
  pds_grabber u_gr (.pix_dval(pix_dval), .pix_lval(pix_lval), .pix_data(pix_data), .got(got), .gd(gd));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ***
  // Checking and closing
  // ***
  task chk(input string n, input logic [31:0] x, input logic [31:0] y);
    n_tests++;
    if (x !== y) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, x, y);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    repeat (20) if (pready !== 1'b1) @(posedge pclk);
    chk("pready", 1, {31'h0, pready});
    if (pready !== 1'b1) test_done;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Odd pixels random over full range so every nonzero shift saturates sometimes
  task line(input logic [3:0] c);
    logic [12:0] u;
    logic [9:0]  v;
    for (int p = 0; p < 16; p++) begin
      @(posedge pclk);
      adc_lval <= 1'b1;
      adc_dval <= 1'b1;
      v = 10'($urandom) & (p[0] ? 10'h3ff : 10'h07f);
      adc_data <= v;
      u = {3'h0, v} << c[1:0];
      v = (|u[12:10]) ? 10'h3ff : u[9:0];
      q.push_back(c[3] ? {2'h0, tbl[p]} : c[2] ? {2'h0, v[9:2]} : v);
    end
    @(posedge pclk);
    adc_lval <= 1'b0;
    adc_dval <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk) if (got === 1'b1) chk("pix_data", 32'(q.pop_front()), 32'(gd));
  initial begin
    {psel, penable, pwrite, adc_dval, adc_lval, presetn} = 6'h0;
    {paddr, pwdata, adc_data} = 54'h0;
    void'($urandom(32'h7eb2));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl", 0, r);
    apb(0, 12'h010, 0);
    chk("pslverr", 1, {31'h0, e});
    apb(1, 12'h008, 0);
    for (int i = 0; i < 16; i++) begin
      tbl[i] = 8'($urandom);
      apb(1, 12'h00c, {24'h0, tbl[i]});
    end
    apb(1, 12'h008, 0);
    apb(0, 12'h00c, 0);
    chk("tbl_data", {24'h0, tbl[0]}, r);
    apb(0, 12'h008, 0);
    chk("tbl_addr", 1, r);
    for (int m = 0; m < 10; m++) begin
      apb(1, 12'h000, m < 8 ? m : m * 4 - 24);
      line(4'(m < 8 ? m : m * 4 - 24));
    end
    apb(0, 12'h004, 0);
    chk("status", 32'h0000_c010, r);
    repeat (20) if (q.size() != 0) @(posedge pclk);
    chk("queue left", 0, q.size());
    test_done;
  end
endmodule // tb_pixel_digital_shift_formatter
